/* File: hw/io_control_select.sv */
// Purpose: I/O control selection for timer general registers with Wishbone register access
// Assumes: Counter values and count / match events come from same-clock timer logic
// Notes: Capture strobes and captured values are registered; bus answers one cycle after request
//
// Contract
// - Low control bits 7-4 select register D
// - Low control bits 3-0 select register C
// - Ch0 B/D code 11xx captures on ch1 count
// - No ch1-count capture when ch1 undivided clock
// - Ch0 buffer mode B disables D capture
// - Ch1 B code 11xx captures on ch0 C event
//
// Design decisions made here: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
module io_control_select #(
    parameter int CNT_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [io_select_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [CNT_W-1:0] ch0_counter_i,
    input wire logic [CNT_W-1:0] ch1_counter_i,
    input wire logic ch1_count_i,
    input wire logic ch0_c_event_i,
    output logic ch0_b_capture_o,
    output logic ch0_d_capture_o,
    output logic ch1_b_capture_o,
    output logic ch0_b_compare_o,
    output logic ch0_d_compare_o,
    output logic ch1_b_compare_o,
    output logic ch2_b_compare_o,
    output logic ch0_d_buffer_o,
    output logic [3:0] ch0_a_field_o,
    output logic [3:0] ch0_c_field_o,
    output logic [3:0] ch3_a_field_o,
    output logic [3:0] ch3_b_field_o,
    output logic [3:0] ch3_c_field_o,
    output logic [3:0] ch3_d_field_o
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ioc_high_ch0;
        logic [7:0] ioc_low_ch0;
        logic [7:0] ioc_ch1;
        logic [7:0] ioc_ch2;
        logic [7:0] ioc_high_ch3;
        logic [7:0] ioc_low_ch3;
        logic buffer_b;
        logic [io_select_pkg::PRESC_W-1:0] presc_ch1;
        logic [io_select_pkg::NUM_CAP-1:0] sticky;
        logic [io_select_pkg::NUM_CAP-1:0] cap_pulse;
        logic ack;
        logic [31:0] rdata;
    } state_s;

    state_s st_r;
    state_s st_nxt;

    capture_sel_if sel_b0 ();
    capture_sel_if sel_d0 ();
    capture_sel_if sel_b1 ();

    logic [CNT_W-1:0] cap_b0_val;
    logic [CNT_W-1:0] cap_d0_val;
    logic [CNT_W-1:0] cap_b1_val;
    logic ch1_fast_clock;
    logic [io_select_pkg::NUM_CAP-1:0] cap_now;
    logic [io_select_pkg::NUM_CAP-1:0] cap_mode;

    // ------------------------------------------------------------------
    // Bus decode helpers
    // ------------------------------------------------------------------
    function automatic logic wr_hit(input logic [io_select_pkg::ADR_W-1:0] off);
        return wb_cyc_i && wb_stb_i && wb_we_i && !st_r.ack && wb_sel_i[0] && wb_adr_i == off;
    endfunction

    function automatic logic [31:0] zext(input logic [CNT_W-1:0] v);
        logic [31:0] w;
        w = '0;
        w[CNT_W-1:0] = v;
        return w;
    endfunction

    // ------------------------------------------------------------------
    // Capture source selection
    // ------------------------------------------------------------------
    assign ch1_fast_clock = st_r.presc_ch1 == io_select_pkg::PRESC_UNDIVIDED;

    assign sel_b0.code = io_select_pkg::upper_field(st_r.ioc_high_ch0);
    assign sel_b0.trigger = ch1_count_i;
    assign sel_b0.suppress = ch1_fast_clock;

    assign sel_d0.code = io_select_pkg::upper_field(st_r.ioc_low_ch0);
    assign sel_d0.trigger = ch1_count_i;
    assign sel_d0.suppress = ch1_fast_clock || st_r.buffer_b;

    assign sel_b1.code = io_select_pkg::upper_field(st_r.ioc_ch1);
    assign sel_b1.trigger = ch0_c_event_i;
    assign sel_b1.suppress = 1'b0;

    capture_source_sel u_sel_b0 (
        .sel_if(sel_b0)
    );

    capture_source_sel u_sel_d0 (
        .sel_if(sel_d0)
    );

    capture_source_sel u_sel_b1 (
        .sel_if(sel_b1)
    );

    assign cap_now = {sel_b1.capture, sel_d0.capture, sel_b0.capture};
    assign cap_mode = {io_select_pkg::is_capture_code(sel_b1.code),
                       io_select_pkg::is_capture_code(sel_d0.code) && !st_r.buffer_b,
                       io_select_pkg::is_capture_code(sel_b0.code)};

    // ------------------------------------------------------------------
    // Captured counter values
    // ------------------------------------------------------------------
    capture_latch #(
        .CNT_W(CNT_W)
    ) u_latch_b0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .capture_i(sel_b0.capture),
        .count_i(ch0_counter_i),
        .value_o(cap_b0_val)
    );

    capture_latch #(
        .CNT_W(CNT_W)
    ) u_latch_d0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .capture_i(sel_d0.capture),
        .count_i(ch0_counter_i),
        .value_o(cap_d0_val)
    );

    capture_latch #(
        .CNT_W(CNT_W)
    ) u_latch_b1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .capture_i(sel_b1.capture),
        .count_i(ch1_counter_i),
        .value_o(cap_b1_val)
    );

    // ------------------------------------------------------------------
    // Register file and bus slave
    // ------------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = wb_cyc_i && wb_stb_i && !st_r.ack;
        st_nxt.cap_pulse = cap_now;

        if (wr_hit(io_select_pkg::OFF_IOC_HIGH_CH0)) begin
            st_nxt.ioc_high_ch0 = wb_dat_i[7:0];
        end
        if (wr_hit(io_select_pkg::OFF_IOC_LOW_CH0)) begin
            st_nxt.ioc_low_ch0 = wb_dat_i[7:0];
        end
        if (wr_hit(io_select_pkg::OFF_IOC_CH1)) begin
            st_nxt.ioc_ch1 = wb_dat_i[7:0];
        end
        if (wr_hit(io_select_pkg::OFF_IOC_CH2)) begin
            st_nxt.ioc_ch2 = wb_dat_i[7:0];
        end
        if (wr_hit(io_select_pkg::OFF_IOC_HIGH_CH3)) begin
            st_nxt.ioc_high_ch3 = wb_dat_i[7:0];
        end
        if (wr_hit(io_select_pkg::OFF_IOC_LOW_CH3)) begin
            st_nxt.ioc_low_ch3 = wb_dat_i[7:0];
        end
        if (wr_hit(io_select_pkg::OFF_MODE_CH0)) begin
            st_nxt.buffer_b = wb_dat_i[io_select_pkg::BUFFER_B_BIT];
        end
        if (wr_hit(io_select_pkg::OFF_CTRL_CH1)) begin
            st_nxt.presc_ch1 = wb_dat_i[io_select_pkg::PRESC_LSB+:io_select_pkg::PRESC_W];
        end

        // Write one to clear; a capture in the same cycle keeps its flag
        if (wr_hit(io_select_pkg::OFF_STATUS)) begin
            st_nxt.sticky = st_r.sticky & ~wb_dat_i[io_select_pkg::STAT_EVENT_LSB+:io_select_pkg::NUM_CAP];
        end
        st_nxt.sticky = st_nxt.sticky | cap_now;

        st_nxt.rdata = '0;
        if (wb_cyc_i && wb_stb_i && !wb_we_i && !st_r.ack) begin
            case (wb_adr_i)
                io_select_pkg::OFF_IOC_HIGH_CH0: begin
                    st_nxt.rdata[7:0] = st_r.ioc_high_ch0;
                end
                io_select_pkg::OFF_IOC_LOW_CH0: begin
                    st_nxt.rdata[7:0] = st_r.ioc_low_ch0;
                end
                io_select_pkg::OFF_IOC_CH1: begin
                    st_nxt.rdata[7:0] = st_r.ioc_ch1;
                end
                io_select_pkg::OFF_IOC_CH2: begin
                    st_nxt.rdata[7:0] = st_r.ioc_ch2;
                end
                io_select_pkg::OFF_IOC_HIGH_CH3: begin
                    st_nxt.rdata[7:0] = st_r.ioc_high_ch3;
                end
                io_select_pkg::OFF_IOC_LOW_CH3: begin
                    st_nxt.rdata[7:0] = st_r.ioc_low_ch3;
                end
                io_select_pkg::OFF_MODE_CH0: begin
                    st_nxt.rdata[io_select_pkg::BUFFER_B_BIT] = st_r.buffer_b;
                end
                io_select_pkg::OFF_CTRL_CH1: begin
                    st_nxt.rdata[io_select_pkg::PRESC_LSB+:io_select_pkg::PRESC_W] = st_r.presc_ch1;
                end
                io_select_pkg::OFF_STATUS: begin
                    st_nxt.rdata[io_select_pkg::STAT_EVENT_LSB+:io_select_pkg::NUM_CAP] = st_r.sticky;
                    st_nxt.rdata[io_select_pkg::STAT_MODE_LSB+:io_select_pkg::NUM_CAP] = cap_mode;
                end
                io_select_pkg::OFF_CAP_B0: begin
                    st_nxt.rdata = zext(cap_b0_val);
                end
                io_select_pkg::OFF_CAP_D0: begin
                    st_nxt.rdata = zext(cap_d0_val);
                end
                io_select_pkg::OFF_CAP_B1: begin
                    st_nxt.rdata = zext(cap_b1_val);
                end
                default: begin
                    st_nxt.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
            st_r.ioc_high_ch0 <= io_select_pkg::IOC_RESET;
            st_r.ioc_low_ch0 <= io_select_pkg::IOC_RESET;
            st_r.ioc_ch1 <= io_select_pkg::IOC_RESET;
            st_r.ioc_ch2 <= io_select_pkg::IOC_RESET;
            st_r.ioc_high_ch3 <= io_select_pkg::IOC_RESET;
            st_r.ioc_low_ch3 <= io_select_pkg::IOC_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign wb_ack_o = st_r.ack;
    assign wb_dat_o = st_r.rdata;

    assign ch0_b_capture_o = st_r.cap_pulse[0];
    assign ch0_d_capture_o = st_r.cap_pulse[1];
    assign ch1_b_capture_o = st_r.cap_pulse[2];

    // Codes other than zero and capture are left to software to avoid
    assign ch0_b_compare_o = sel_b0.compare_mode;
    assign ch0_d_compare_o = sel_d0.compare_mode && !st_r.buffer_b;
    assign ch1_b_compare_o = sel_b1.compare_mode;
    assign ch2_b_compare_o = io_select_pkg::upper_field(st_r.ioc_ch2) == io_select_pkg::COMPARE_OFF_CODE;
    assign ch0_d_buffer_o = st_r.buffer_b;

    assign ch0_a_field_o = io_select_pkg::lower_field(st_r.ioc_high_ch0);
    assign ch0_c_field_o = io_select_pkg::lower_field(st_r.ioc_low_ch0);
    assign ch3_a_field_o = io_select_pkg::lower_field(st_r.ioc_high_ch3);
    assign ch3_b_field_o = io_select_pkg::upper_field(st_r.ioc_high_ch3);
    assign ch3_c_field_o = io_select_pkg::lower_field(st_r.ioc_low_ch3);
    assign ch3_d_field_o = io_select_pkg::upper_field(st_r.ioc_low_ch3);
endmodule // io_control_select

/* File: hw/io_select_pkg.sv */
// Purpose: Shared constants and helpers for the timer I/O control selection block
// Assumes: Byte-wide registers sit in the low lane of aligned 32-bit Wishbone words
// Notes: Offsets are byte addresses on the register bus
package io_select_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int ADR_W = 6;
    localparam logic [ADR_W-1:0] OFF_IOC_HIGH_CH0 = 6'h00;
    localparam logic [ADR_W-1:0] OFF_IOC_LOW_CH0 = 6'h04;
    localparam logic [ADR_W-1:0] OFF_IOC_CH1 = 6'h08;
    localparam logic [ADR_W-1:0] OFF_IOC_CH2 = 6'h0c;
    localparam logic [ADR_W-1:0] OFF_IOC_HIGH_CH3 = 6'h10;
    localparam logic [ADR_W-1:0] OFF_IOC_LOW_CH3 = 6'h14;
    localparam logic [ADR_W-1:0] OFF_MODE_CH0 = 6'h18;
    localparam logic [ADR_W-1:0] OFF_CTRL_CH1 = 6'h1c;
    localparam logic [ADR_W-1:0] OFF_STATUS = 6'h20;
    localparam logic [ADR_W-1:0] OFF_CAP_B0 = 6'h24;
    localparam logic [ADR_W-1:0] OFF_CAP_D0 = 6'h28;
    localparam logic [ADR_W-1:0] OFF_CAP_B1 = 6'h2c;

    // ------------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------------
    localparam int FIELD_W = 4;
    localparam int FIELD_UPPER_LSB = 4;
    localparam int FIELD_LOWER_LSB = 0;
    localparam logic [7:0] IOC_RESET = 8'h00;
    localparam logic [1:0] CAPTURE_CODE_TOP = 2'h3;
    localparam logic [FIELD_W-1:0] COMPARE_OFF_CODE = 4'h0;
    localparam int BUFFER_B_BIT = 5;
    localparam int PRESC_LSB = 0;
    localparam int PRESC_W = 3;
    localparam logic [PRESC_W-1:0] PRESC_UNDIVIDED = 3'h0;
    localparam int STAT_EVENT_LSB = 0;
    localparam int STAT_MODE_LSB = 4;
    localparam int NUM_CAP = 3;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic is_capture_code(input logic [FIELD_W-1:0] code);
        return code[FIELD_W-1:FIELD_W-2] == CAPTURE_CODE_TOP;
    endfunction

    function automatic logic [FIELD_W-1:0] upper_field(input logic [7:0] r);
        return r[FIELD_UPPER_LSB+:FIELD_W];
    endfunction

    function automatic logic [FIELD_W-1:0] lower_field(input logic [7:0] r);
        return r[FIELD_LOWER_LSB+:FIELD_W];
    endfunction
endpackage

/* File: hw/capture_sel_if.sv */
// Purpose: Carries one general register's control code and capture trigger to its selector
// Assumes: Single clock domain, all signals combinational between modules
// Notes: ctrl side is the owner of the control registers
`timescale 1ns/10ps
interface capture_sel_if;
    logic [3:0] code;
    logic trigger;
    logic suppress;
    logic capture;
    logic compare_mode;

    modport ctrl (output code, output trigger, output suppress, input capture, input compare_mode);
    modport sel (input code, input trigger, input suppress, output capture, output compare_mode);
endinterface

/* File: hw/capture_source_sel.sv */
// Purpose: Decodes one general register's control code into a capture strobe
// Assumes: trigger is a one-cycle pulse from logic on the same clock
// Notes: Only the all-zero code and the capture code are meaningful here
`timescale 1ns/10ps
module capture_source_sel (
    capture_sel_if.sel sel_if
);
    assign sel_if.capture = io_select_pkg::is_capture_code(sel_if.code) && !sel_if.suppress && sel_if.trigger;
    assign sel_if.compare_mode = sel_if.code == io_select_pkg::COMPARE_OFF_CODE;
endmodule // capture_source_sel

/* File: hw/capture_latch.sv */
// Purpose: Holds the counter value taken at the last capture strobe
// Assumes: capture_i is a one-cycle pulse
// Notes: Value stands until the next capture
`timescale 1ns/10ps
module capture_latch #(
    parameter int CNT_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic capture_i,
    input wire logic [CNT_W-1:0] count_i,
    output logic [CNT_W-1:0] value_o
);
    typedef struct packed {
        logic [CNT_W-1:0] value;
    } latch_s;

    latch_s st_r;
    latch_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (capture_i) begin
            st_nxt.value = count_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign value_o = st_r.value;
endmodule // capture_latch

/* File: tb/io_control_select_asserts.sv */
// Purpose: Port-level checker for the timer I/O control selection block
// Assumes: Single clock, synchronous active-high reset
// Notes: Bound from the testbench top file
`timescale 1ns/10ps
module io_control_select_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic ch1_count_i,
    input wire logic ch0_c_event_i,
    input wire logic ch0_b_capture_o,
    input wire logic ch0_d_capture_o,
    input wire logic ch1_b_capture_o,
    input wire logic ch0_b_compare_o,
    input wire logic ch0_d_compare_o,
    input wire logic ch1_b_compare_o,
    input wire logic ch0_d_buffer_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged next cycle");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without a request");
    a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    // ------------------------------------------------------------------
    // Capture selection
    // ------------------------------------------------------------------
    a_b0_cap_cause: assert property (ch0_b_capture_o |-> $past(ch1_count_i) && !$past(ch0_b_compare_o))
        else $error("ch0 B capture without its trigger");
    a_d0_cap_cause: assert property (ch0_d_capture_o |-> $past(ch1_count_i) && !$past(ch0_d_buffer_o))
        else $error("ch0 D capture without trigger or while buffered");
    a_b1_cap_cause: assert property (ch1_b_capture_o |-> $past(ch0_c_event_i) && !$past(ch1_b_compare_o))
        else $error("ch1 B capture without its trigger");
    a_buffer_blocks_d: assert property (ch0_d_buffer_o |-> !ch0_d_compare_o)
        else $error("ch0 D compare active while buffered");
    c_write: cover property (wb_ack_o && $past(wb_we_i));
    c_b0_cap: cover property (ch0_b_capture_o);
    c_d0_cap: cover property (ch0_d_capture_o);
    c_b1_cap: cover property (ch1_b_capture_o);
endmodule // io_control_select_asserts

/* File: tb/io_control_select_tb.sv */
// Purpose: Self-checking bench for the timer I/O control selection block
// Assumes: Wishbone classic single cycles, byte registers in lane 0
// Notes: Triggers are one-cycle pulses driven by the bench
`timescale 1ns/10ps
module io_control_select_tb;
    localparam int CNT_W = 16;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [io_select_pkg::ADR_W-1:0] wb_adr_i = '0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [CNT_W-1:0] ch0_counter_i = '0;
    logic [CNT_W-1:0] ch1_counter_i = '0;
    logic ch1_count_i = 1'b0;
    logic ch0_c_event_i = 1'b0;
    logic ch0_b_capture_o, ch0_d_capture_o, ch1_b_capture_o;
    logic ch0_b_compare_o, ch0_d_compare_o, ch1_b_compare_o, ch2_b_compare_o, ch0_d_buffer_o;
    logic [3:0] ch0_a_field_o, ch0_c_field_o, ch3_a_field_o, ch3_b_field_o, ch3_c_field_o, ch3_d_field_o;
    logic [31:0] rd;
    logic [3:0] code;
    logic cap;
    int n_mismatch = 0;
    int comparisons = 0;

    io_control_select #(.CNT_W(CNT_W)) io_control_select_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ch0_counter_i(ch0_counter_i), .ch1_counter_i(ch1_counter_i),
        .ch1_count_i(ch1_count_i), .ch0_c_event_i(ch0_c_event_i), .ch0_b_capture_o(ch0_b_capture_o),
        .ch0_d_capture_o(ch0_d_capture_o), .ch1_b_capture_o(ch1_b_capture_o), .ch0_b_compare_o(ch0_b_compare_o),
        .ch0_d_compare_o(ch0_d_compare_o), .ch1_b_compare_o(ch1_b_compare_o), .ch2_b_compare_o(ch2_b_compare_o),
        .ch0_d_buffer_o(ch0_d_buffer_o), .ch0_a_field_o(ch0_a_field_o), .ch0_c_field_o(ch0_c_field_o),
        .ch3_a_field_o(ch3_a_field_o), .ch3_b_field_o(ch3_b_field_o), .ch3_c_field_o(ch3_c_field_o),
        .ch3_d_field_o(ch3_d_field_o));

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Holds the request until ack is sampled high, then releases it
    task automatic wb_access(input logic we, input logic [5:0] a, input logic [7:0] d, output logic [31:0] q);
        int i;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        wb_sel_i <= 4'h1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        if (i == 20) begin
            n_mismatch++;
            tally_and_finish();
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb_access(1'b1, a, d, q);
    endtask

    task automatic rd_check(input logic [5:0] a, input logic [31:0] exp);
        wb_access(1'b0, a, 8'h00, rd);
        check(rd, exp);
    endtask

    // One-cycle trigger pulse; returns once the registered strobes are visible
    task automatic pulse(input logic cnt, input logic evt);
        @(posedge clk_i);
        ch1_count_i <= cnt;
        ch0_c_event_i <= evt;
        @(posedge clk_i);
        ch1_count_i <= 1'b0;
        ch0_c_event_i <= 1'b0;
        #1;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        check({24'h0, ch0_c_field_o, ch3_d_field_o}, 32'h0);
        check({28'h0, ch0_b_compare_o, ch0_d_compare_o, ch1_b_compare_o, ch2_b_compare_o}, 32'hf);
        rd_check(io_select_pkg::OFF_IOC_LOW_CH0, 32'h0);
        rd_check(io_select_pkg::OFF_IOC_LOW_CH3, 32'h0);
        $display("reset values done");

        wr(io_select_pkg::OFF_IOC_LOW_CH3, 8'h3c);
        rd_check(io_select_pkg::OFF_IOC_LOW_CH3, 32'h3c);
        check({24'h0, ch3_d_field_o, ch3_c_field_o}, 32'h3c);
        wr(io_select_pkg::OFF_IOC_HIGH_CH3, 8'ha5);
        check({24'h0, ch3_b_field_o, ch3_a_field_o}, 32'ha5);
        rd_check(6'h3c, 32'h0);
        $display("low register fields done");

        wr(io_select_pkg::OFF_IOC_HIGH_CH0, 8'hc0);
        wr(io_select_pkg::OFF_IOC_LOW_CH0, 8'hc0);
        pulse(1'b1, 1'b0);
        check({30'h0, ch0_b_capture_o, ch0_d_capture_o}, 32'h0);
        $display("undivided clock suppression done");

        wr(io_select_pkg::OFF_CTRL_CH1, 8'h01);
        for (int c = 0; c < 16; c++) begin
            code = c[3:0];
            cap = (code[3:2] == 2'b11);
            wr(io_select_pkg::OFF_IOC_HIGH_CH0, {code, ~code});
            wr(io_select_pkg::OFF_IOC_LOW_CH0, {code, ~code});
            wr(io_select_pkg::OFF_IOC_CH1, {code, 4'h0});
            wr(io_select_pkg::OFF_IOC_CH2, {code, 4'h0});
            check({24'h0, ch0_a_field_o, ch0_c_field_o}, {24'h0, ~code, ~code});
            check({28'h0, ch0_b_compare_o, ch0_d_compare_o, ch1_b_compare_o, ch2_b_compare_o},
                  {28'h0, {4{code == 4'h0}}});
            ch0_counter_i <= 16'h1000 + 16'(c);
            ch1_counter_i <= 16'h2000 + 16'(c);
            pulse(1'b1, 1'b1);
            check({29'h0, ch0_b_capture_o, ch0_d_capture_o, ch1_b_capture_o}, {29'h0, {3{cap}}});
            if (cap) begin
                rd_check(io_select_pkg::OFF_CAP_B0, 32'h1000 + 32'(c));
                rd_check(io_select_pkg::OFF_CAP_D0, 32'h1000 + 32'(c));
                rd_check(io_select_pkg::OFF_CAP_B1, 32'h2000 + 32'(c));
            end
        end
        $display("control code sweep done");

        // Sticky flags set by the capture codes, mode bits from the last code 1111
        rd_check(io_select_pkg::OFF_STATUS, 32'h77);
        wr(io_select_pkg::OFF_STATUS, 8'h07);
        rd_check(io_select_pkg::OFF_STATUS, 32'h70);
        $display("status flags done");

        wr(io_select_pkg::OFF_IOC_LOW_CH0, 8'hc0);
        wr(io_select_pkg::OFF_MODE_CH0, 8'h20);
        check({30'h0, ch0_d_buffer_o, ch0_d_compare_o}, 32'h2);
        pulse(1'b1, 1'b0);
        check({30'h0, ch0_b_capture_o, ch0_d_capture_o}, 32'h2);
        $display("buffer mode done");

        @(posedge clk_i);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        rd_check(io_select_pkg::OFF_IOC_HIGH_CH0, 32'h0);
        check({28'h0, ch0_c_field_o}, 32'h0);
        $display("second reset done");
        tally_and_finish();
    end
endmodule // io_control_select_tb

bind io_control_select io_control_select_asserts asserts_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ch1_count_i(ch1_count_i),
    .ch0_c_event_i(ch0_c_event_i), .ch0_b_capture_o(ch0_b_capture_o), .ch0_d_capture_o(ch0_d_capture_o),
    .ch1_b_capture_o(ch1_b_capture_o), .ch0_b_compare_o(ch0_b_compare_o), .ch0_d_compare_o(ch0_d_compare_o),
    .ch1_b_compare_o(ch1_b_compare_o), .ch0_d_buffer_o(ch0_d_buffer_o));
